/* File: rtl/mtsf_defines.vh */
// Constants of the Modbus TCP server framing block
`ifndef MTSF_DEFINES_VH
`define MTSF_DEFINES_VH

// ----------------------------------------
// Function and exception codes
// ----------------------------------------
`define MTSF_FC_RD 8'h03
`define MTSF_FC_WR 8'h10
`define MTSF_FC_LOG 8'h46
`define MTSF_FC_ERR 8'h80
`define MTSF_EX_FUNC 8'h01
`define MTSF_EX_ADDR 8'h02
`define MTSF_EX_DATA 8'h03
`define MTSF_EX_BUSY 8'h06

// ----------------------------------------
// Header fields
// ----------------------------------------
`define MTSF_UNIT_ZERO 8'h00
`define MTSF_UNIT_ALL 8'hff
`define MTSF_PROTO_ID 8'h00
`define MTSF_MAX_QTY 16'h007d
`define MTSF_LEN_OFS 16'h0005
`define MTSF_LEN_WR_EXTRA 16'h0007

// ----------------------------------------
// Byte positions in a frame
// ----------------------------------------
`define MTSF_POS_TID_H 16'h0000
`define MTSF_POS_TID_L 16'h0001
`define MTSF_POS_PRO_H 16'h0002
`define MTSF_POS_PRO_L 16'h0003
`define MTSF_POS_LEN_H 16'h0004
`define MTSF_POS_LEN_L 16'h0005
`define MTSF_POS_UNIT 16'h0006
`define MTSF_POS_FC 16'h0007
`define MTSF_POS_ST_H 16'h0008
`define MTSF_POS_ST_L 16'h0009
`define MTSF_POS_QTY_H 16'h000a
`define MTSF_POS_QTY_L 16'h000b
`define MTSF_POS_BCNT 16'h000c
`define MTSF_POS_DATA 16'h000d

// ----------------------------------------
// Response lengths and buffer
// ----------------------------------------
`define MTSF_RLEN_ERR 16'h0003
`define MTSF_RLEN_PAIR 16'h0006
`define MTSF_RLEN_RD 16'h0003
`define MTSF_BUF_DEPTH 2

`endif

/* File: rtl/mtsf_buf.v */
// Small shift buffer between the response generator and the link
`timescale 1ns/10ps

module mtsf_buf #(
  parameter WIDTH = 9,
  parameter DEPTH = 2
) (
  input wire clock_i, // System clock
  input wire reset_i, // Synchronous reset
  input wire ce_i, // Clock enable
  input wire [WIDTH-1:0] in_data_i, // Word in
  input wire in_valid_i, // Word in valid
  output wire in_ready_o, // Room for a word
  output wire [WIDTH-1:0] out_data_o, // Head word
  output wire out_valid_o, // Head valid
  input wire out_ready_i // Head taken
);

  reg [DEPTH*WIDTH-1:0] mem_q;
  reg [DEPTH*WIDTH-1:0] mem_d;
  reg [DEPTH-1:0] vld_q;
  reg [DEPTH-1:0] vld_d;
  reg pop;
  reg push;
  reg done;
  integer i;

  // ----------------------------------------
  // Shift on pop, fill first free slot
  // ----------------------------------------
  always @* begin
    pop = out_ready_i & vld_q[0];
    push = in_valid_i & ~vld_q[DEPTH-1];
    vld_d = pop ? (vld_q >> 1) : vld_q;
    mem_d = pop ? (mem_q >> WIDTH) : mem_q;
    done = 1'b0;
    for (i = 0; i < DEPTH; i = i + 1) begin
      if (push && !done && !vld_d[i]) begin
        vld_d[i] = 1'b1;
        mem_d[i*WIDTH +: WIDTH] = in_data_i;
        done = 1'b1;
      end
    end
  end

  always @(posedge clock_i) begin
    if (reset_i) begin
      vld_q <= {DEPTH{1'b0}};
      mem_q <= {(DEPTH*WIDTH){1'b0}};
    end else if (ce_i) begin
      vld_q <= vld_d;
      mem_q <= mem_d;
    end
  end

  assign in_ready_o = ~vld_q[DEPTH-1];
  assign out_data_o = mem_q[WIDTH-1:0];
  assign out_valid_o = vld_q[0];

endmodule // mtsf_buf

/* File: rtl/mtsf_core.v */
// Modbus TCP server framing: query parser, store access, response builder
`timescale 1ns/10ps
`include "mtsf_defines.vh"

// Contract
// - Response copies the query's 16-bit transaction identifier, high byte first.
// - Nonzero protocol identifier drops the query silently; responses carry zero.
// - Length field counts bytes from unit identifier through last data byte.
// - Bad function, address or data yields an error response instead.
// - Error function byte is requested function plus 80 hex, header kept.
// - Error response ends with one exception-code byte.
// - Drive-profile access uses only read (03) and multi-write (10).
// - Drive-profile start address is the object index; sub-indices follow consecutively.
// - A 32-bit sub-index takes two registers, most significant word first.
// - Sub-index 0 reads the highest sub-index; data sent high byte first.
// - Successful multi-write answers length six echoing unit, function, start, quantity.
// - Log query has length two; answer length six, start and count.
// - Outside drive profile, address field is holding register number minus 40001.
// - Log records only 03, 06, 10 accesses; else reports zero start and count. Code logs 03 and 10 only; 06 gets exception 01.
// - Exception codes: 01 function, 02 address, 03 data, 06 busy.
module mtsf_core #(
  parameter MAX_QTY = `MTSF_MAX_QTY,
  parameter BUF_DEPTH = `MTSF_BUF_DEPTH
) (
  input wire clock_i, // System clock, 25 MHz
  input wire reset_i, // Synchronous reset, active high
  input wire ce_i, // Clock enable, freezes all state when low
  input wire [7:0] rx_data_i, // Query byte
  input wire rx_valid_i, // Query byte valid
  output wire rx_ready_o, // Query byte accepted
  output wire [7:0] tx_data_o, // Response byte
  output wire tx_last_o, // Last byte of response
  output wire tx_valid_o, // Response byte valid
  input wire tx_ready_i, // Response byte taken
  output wire acc_req_o, // Store access strobe
  output wire acc_we_o, // Store access is a write
  output wire [15:0] acc_addr_o, // Register address field value
  output wire [15:0] acc_wdata_o, // Register write data
  input wire [15:0] acc_rdata_i, // Register read data, same cycle
  input wire acc_ok_i, // Register exists and is accessible
  input wire acc_busy_i // Store busy with other work
);

  localparam [1:0] S_RECV = 2'd0;
  localparam [1:0] S_EVAL = 2'd1;
  localparam [1:0] S_SCAN = 2'd2;
  localparam [1:0] S_SEND = 2'd3;

  reg [1:0] st_q;
  reg rdy_q;
  reg [15:0] pos_q;
  reg [15:0] tid_q;
  reg pbad_q;
  reg [15:0] len_q;
  reg [7:0] unit_q;
  reg [7:0] fc_q;
  reg [15:0] start_q;
  reg [15:0] qty_q;
  reg [7:0] bcnt_q;
  reg [7:0] hi_q;
  reg [15:0] okc_q;
  reg busy_q;
  reg err_q;
  reg [7:0] exc_q;
  reg [15:0] rlen_q;
  reg [15:0] ra_q;
  reg [15:0] rb_q;
  reg [15:0] log_st_q;
  reg [15:0] log_cnt_q;
  reg [15:0] w_q;
  reg [15:0] tp_q;
  reg have_q;
  reg [15:0] wd_q;
  reg req_q;
  reg we_q;
  reg [15:0] addr_q;
  reg [15:0] wdata_q;

  reg [7:0] src_byte;
  reg src_need;
  wire src_last;
  wire src_valid;
  wire buf_ready;
  wire [15:0] p;
  wire [15:0] dofs;
  wire rx_take;

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function qty_bad;
    input [15:0] q;
    begin
      qty_bad = (q == 16'h0000) || (q > MAX_QTY[15:0]);
    end
  endfunction

  function [7:0] pick;
    input [15:0] wd;
    input lo;
    begin
      pick = lo ? wd[7:0] : wd[15:8];
    end
  endfunction

  assign rx_take = (st_q == S_RECV) && rdy_q && rx_valid_i;
  assign dofs = pos_q - `MTSF_POS_DATA;
  assign p = tp_q - `MTSF_POS_ST_H;
  assign src_last = ({1'b0, tp_q} == {1'b0, rlen_q} + {1'b0, `MTSF_LEN_OFS});
  assign src_valid = (st_q == S_SEND) && !(src_need && !have_q);

  // ----------------------------------------
  // Response byte generator
  // ----------------------------------------
  always @* begin
    src_need = 1'b0;
    src_byte = 8'h00;
    if (tp_q == `MTSF_POS_TID_H) begin
      src_byte = tid_q[15:8];
    end else if (tp_q == `MTSF_POS_TID_L) begin
      src_byte = tid_q[7:0];
    end else if (tp_q == `MTSF_POS_PRO_H || tp_q == `MTSF_POS_PRO_L) begin
      src_byte = `MTSF_PROTO_ID;
    end else if (tp_q == `MTSF_POS_LEN_H) begin
      src_byte = rlen_q[15:8];
    end else if (tp_q == `MTSF_POS_LEN_L) begin
      src_byte = rlen_q[7:0];
    end else if (tp_q == `MTSF_POS_UNIT) begin
      src_byte = unit_q;
    end else if (tp_q == `MTSF_POS_FC) begin
      src_byte = err_q ? (fc_q | `MTSF_FC_ERR) : fc_q;
    end else if (err_q) begin
      src_byte = exc_q;
    end else if (fc_q == `MTSF_FC_RD) begin
      if (p == 16'h0000) begin
        src_byte = bcnt_q;
      end else begin
        src_need = p[0];
        src_byte = pick(wd_q, ~(p[0]));
      end
    end else if (p[15:1] == 15'h0000) begin
      src_byte = pick(ra_q, p[0]);
    end else begin
      src_byte = pick(rb_q, p[0]);
    end
  end

  // ----------------------------------------
  // Main sequencer
  // ----------------------------------------
  always @(posedge clock_i) begin
    if (reset_i) begin
      st_q <= S_RECV;
      rdy_q <= 1'b1;
      pos_q <= 16'h0000;
      tid_q <= 16'h0000;
      pbad_q <= 1'b0;
      len_q <= 16'h0000;
      unit_q <= 8'h00;
      fc_q <= 8'h00;
      start_q <= 16'h0000;
      qty_q <= 16'h0000;
      bcnt_q <= 8'h00;
      hi_q <= 8'h00;
      okc_q <= 16'h0000;
      busy_q <= 1'b0;
      err_q <= 1'b0;
      exc_q <= 8'h00;
      rlen_q <= 16'h0000;
      ra_q <= 16'h0000;
      rb_q <= 16'h0000;
      log_st_q <= 16'h0000;
      log_cnt_q <= 16'h0000;
      w_q <= 16'h0000;
      tp_q <= 16'h0000;
      have_q <= 1'b0;
      wd_q <= 16'h0000;
      req_q <= 1'b0;
      we_q <= 1'b0;
      addr_q <= 16'h0000;
      wdata_q <= 16'h0000;
    end else if (ce_i) begin
      req_q <= 1'b0;
      case (st_q)
        S_RECV: begin
          if (req_q && we_q) begin
            okc_q <= okc_q + {15'h0000, acc_ok_i};
            busy_q <= busy_q | acc_busy_i;
          end
          if (rx_take) begin
            pos_q <= pos_q + 16'h0001;
            if (pos_q == `MTSF_POS_TID_H) tid_q[15:8] <= rx_data_i;
            else if (pos_q == `MTSF_POS_TID_L) tid_q[7:0] <= rx_data_i;
            else if (pos_q == `MTSF_POS_PRO_H || pos_q == `MTSF_POS_PRO_L)
              pbad_q <= pbad_q | (rx_data_i != `MTSF_PROTO_ID);
            else if (pos_q == `MTSF_POS_LEN_H) len_q[15:8] <= rx_data_i;
            else if (pos_q == `MTSF_POS_LEN_L) len_q[7:0] <= rx_data_i;
            else if (pos_q == `MTSF_POS_UNIT) unit_q <= rx_data_i;
            else if (pos_q == `MTSF_POS_FC) fc_q <= rx_data_i;
            else if (pos_q == `MTSF_POS_ST_H) start_q[15:8] <= rx_data_i;
            else if (pos_q == `MTSF_POS_ST_L) start_q[7:0] <= rx_data_i;
            else if (pos_q == `MTSF_POS_QTY_H) qty_q[15:8] <= rx_data_i;
            else if (pos_q == `MTSF_POS_QTY_L) qty_q[7:0] <= rx_data_i;
            else if (pos_q == `MTSF_POS_BCNT) bcnt_q <= rx_data_i;
            else if (!dofs[0]) hi_q <= rx_data_i;
            else if (fc_q == `MTSF_FC_WR && !pbad_q && !qty_bad(qty_q) &&
                     {8'h00, bcnt_q} == {qty_q[14:0], 1'b0} && dofs[15:1] < qty_q[14:0]) begin
              req_q <= 1'b1;
              we_q <= 1'b1;
              addr_q <= start_q + {1'b0, dofs[15:1]};
              wdata_q <= {hi_q, rx_data_i};
            end
            // Frame ends after the byte count given by the length field
            if (pos_q >= `MTSF_POS_FC && {1'b0, pos_q} >= {1'b0, len_q} + {1'b0, `MTSF_LEN_OFS}) begin
              rdy_q <= 1'b0;
              st_q <= S_EVAL;
            end
          end
        end
        S_EVAL: begin
          if (req_q && we_q) begin
            okc_q <= okc_q + {15'h0000, acc_ok_i};
            busy_q <= busy_q | acc_busy_i;
          end
          tp_q <= 16'h0000;
          w_q <= 16'h0000;
          have_q <= 1'b0;
          err_q <= 1'b0;
          rlen_q <= `MTSF_RLEN_PAIR;
          ra_q <= start_q;
          rb_q <= qty_q;
          if (req_q && we_q) begin
            st_q <= S_EVAL;
          end else if (pbad_q || (unit_q != `MTSF_UNIT_ZERO && unit_q != `MTSF_UNIT_ALL)) begin
            st_q <= S_RECV;
          end else if (fc_q == `MTSF_FC_RD) begin
            if (qty_bad(qty_q)) begin
              err_q <= 1'b1;
              exc_q <= `MTSF_EX_DATA;
            end
            st_q <= qty_bad(qty_q) ? S_SEND : S_SCAN;
          end else if (fc_q == `MTSF_FC_WR) begin
            st_q <= S_SEND;
            if (qty_bad(qty_q) || {8'h00, bcnt_q} != {qty_q[14:0], 1'b0} ||
                len_q != {8'h00, bcnt_q} + `MTSF_LEN_WR_EXTRA) begin
              err_q <= 1'b1;
              exc_q <= `MTSF_EX_DATA;
            end else if (busy_q) begin
              err_q <= 1'b1;
              exc_q <= `MTSF_EX_BUSY;
            end else if (okc_q == 16'h0000) begin
              err_q <= 1'b1;
              exc_q <= `MTSF_EX_ADDR;
            end else begin
              log_st_q <= start_q;
              log_cnt_q <= okc_q;
            end
          end else if (fc_q == `MTSF_FC_LOG) begin
            st_q <= S_SEND;
            ra_q <= log_st_q;
            rb_q <= log_cnt_q;
          end else begin
            st_q <= S_SEND;
            err_q <= 1'b1;
            exc_q <= `MTSF_EX_FUNC;
          end
          // Errors and other functions clear the log
          if (!(req_q && we_q) && !(fc_q == `MTSF_FC_RD && !qty_bad(qty_q))) begin
            if (!(fc_q == `MTSF_FC_WR && !qty_bad(qty_q) && !busy_q && okc_q != 16'h0000 &&
                {8'h00, bcnt_q} == {qty_q[14:0], 1'b0} &&
                len_q == {8'h00, bcnt_q} + `MTSF_LEN_WR_EXTRA)) begin
              log_st_q <= 16'h0000;
              log_cnt_q <= 16'h0000;
            end
          end
          if (!(req_q && we_q)) begin
            okc_q <= 16'h0000;
            busy_q <= 1'b0;
            pbad_q <= 1'b0;
            pos_q <= 16'h0000;
            if (pbad_q || (unit_q != `MTSF_UNIT_ZERO && unit_q != `MTSF_UNIT_ALL)) rdy_q <= 1'b1;
          end
        end
        S_SCAN: begin
          // Pre-read pass counts accessible registers before answering
          if (req_q) begin
            okc_q <= okc_q + {15'h0000, acc_ok_i};
            busy_q <= busy_q | acc_busy_i;
            w_q <= w_q + 16'h0001;
          end else if (w_q == qty_q) begin
            st_q <= S_SEND;
            w_q <= 16'h0000;
            rlen_q <= `MTSF_RLEN_RD + {qty_q[14:0], 1'b0};
            bcnt_q <= {qty_q[6:0], 1'b0};
            if (busy_q) begin
              err_q <= 1'b1;
              exc_q <= `MTSF_EX_BUSY;
            end else if (okc_q == 16'h0000) begin
              err_q <= 1'b1;
              exc_q <= `MTSF_EX_ADDR;
            end
            log_st_q <= (busy_q || okc_q == 16'h0000) ? 16'h0000 : start_q;
            log_cnt_q <= (busy_q || okc_q == 16'h0000) ? 16'h0000 : okc_q;
            okc_q <= 16'h0000;
            busy_q <= 1'b0;
          end else begin
            req_q <= 1'b1;
            we_q <= 1'b0;
            addr_q <= start_q + w_q;
          end
        end
        default: begin
          if (err_q) rlen_q <= `MTSF_RLEN_ERR;
          if (src_need && !have_q) begin
            if (req_q) begin
              wd_q <= acc_ok_i ? acc_rdata_i : 16'h0000;
              have_q <= 1'b1;
              w_q <= w_q + 16'h0001;
            end else begin
              req_q <= 1'b1;
              we_q <= 1'b0;
              addr_q <= start_q + w_q;
            end
          end else if (src_valid && buf_ready && !(err_q && rlen_q != `MTSF_RLEN_ERR)) begin
            tp_q <= tp_q + 16'h0001;
            if (!src_need && fc_q == `MTSF_FC_RD && tp_q != `MTSF_POS_ST_H) have_q <= 1'b0;
            if (src_last) begin
              st_q <= S_RECV;
              rdy_q <= 1'b1;
            end
          end
        end
      endcase
    end
  end

  // ----------------------------------------
  // Output buffer
  // ----------------------------------------
  mtsf_buf #(
    .WIDTH(9),
    .DEPTH(BUF_DEPTH)
  ) u_buf (
    .clock_i(clock_i),
    .reset_i(reset_i),
    .ce_i(ce_i),
    .in_data_i({src_last, src_byte}),
    .in_valid_i(src_valid && !(err_q && rlen_q != `MTSF_RLEN_ERR)),
    .in_ready_o(buf_ready),
    .out_data_o({tx_last_o, tx_data_o}),
    .out_valid_o(tx_valid_o),
    .out_ready_i(tx_ready_i)
  );

  assign rx_ready_o = rdy_q;
  assign acc_req_o = req_q;
  assign acc_we_o = we_q;
  assign acc_addr_o = addr_q;
  assign acc_wdata_o = wdata_q;

endmodule // mtsf_core

/* File: bench/mtsf_store.sv */
// Behavioural register store on the far side of the access port
`timescale 1ns/10ps
module mtsf_store (
  input wire logic clock_i, // System clock
  input wire logic req_i, // Access strobe
  input wire logic we_i, // Access is a write
  input wire logic [15:0] addr_i, // Raw address field
  input wire logic [15:0] wdata_i, // Write word
  input wire logic busy_i, // Bench forces busy
  output logic [15:0] rdata_o, // Read word, same cycle
  output logic ok_o, // Register exists
  output logic busy_o // Busy answer
);
  logic [15:0] mem_q [0:7];
  // Object at 6048: highest sub-index, then 32-bit sub-index MSW first
  initial mem_q = '{16'h0002, 16'h0708, 16'h0000, 16'h0005, 16'h0000, 16'h0000, 16'h0000, 16'h0000};
  assign ok_o = (addr_i[15:3] == 13'h0c09);
  assign rdata_o = ok_o ? mem_q[addr_i[2:0]] : 16'h0000;
  assign busy_o = busy_i;
  always @(posedge clock_i) begin
    if (req_i && we_i && ok_o && !busy_i) begin
      mem_q[addr_i[2:0]] <= wdata_i;
    end
  end
endmodule // mtsf_store

/* File: bench/mtsf_checker.sv */
// Port-level assertions on the framing block
`timescale 1ns/10ps
module mtsf_checker (
  input wire clock_i, // System clock
  input wire reset_i, // Synchronous reset
  input wire rx_ready_o, // Query accepted
  input wire [7:0] tx_data_o, // Response byte
  input wire tx_last_o, // Last byte
  input wire tx_valid_o, // Byte valid
  input wire tx_ready_i, // Byte taken
  input wire acc_req_o, // Access strobe
  input wire acc_we_o // Access is a write
);
  default clocking @(posedge clock_i); endclocking
  default disable iff (reset_i);
  logic [15:0] cnt_q;
  logic [15:0] len_q;
  logic [7:0] fc_q;
  // ----------------------------------------
  // Response byte position tracking
  // ----------------------------------------
  always @(posedge clock_i) begin
    if (reset_i) begin
      cnt_q <= 16'h0000;
      len_q <= 16'h0000;
      fc_q <= 8'h00;
    end else if (tx_valid_o && tx_ready_i) begin
      cnt_q <= tx_last_o ? 16'h0000 : cnt_q + 16'h0001;
      if (cnt_q == 16'h0004) len_q[15:8] <= tx_data_o;
      if (cnt_q == 16'h0005) len_q[7:0] <= tx_data_o;
      if (cnt_q == 16'h0007) fc_q <= tx_data_o;
    end
  end
  sequence s_held;
    ##1 tx_valid_o && $stable(tx_data_o) && $stable(tx_last_o);
  endsequence
  sequence s_err_code;
    tx_valid_o && cnt_q == 16'h0008 && fc_q[7];
  endsequence
  property p_rst;
    disable iff (1'b0) reset_i |=> !tx_valid_o && !acc_req_o && rx_ready_o;
  endproperty
  property p_hold;
    tx_valid_o && !tx_ready_i |-> s_held;
  endproperty
  property p_blk;
    $rose(tx_valid_o) |-> !rx_ready_o;
  endproperty
  property p_wr;
    acc_req_o && acc_we_o |=> !acc_req_o;
  endproperty
  property p_pro;
    tx_valid_o && (cnt_q == 16'h0002 || cnt_q == 16'h0003) |-> tx_data_o == 8'h00;
  endproperty
  property p_len;
    tx_valid_o && tx_last_o |-> cnt_q == len_q + 16'h0005;
  endproperty
  property p_err_end;
    s_err_code |-> tx_last_o;
  endproperty
  property p_exc;
    s_err_code |-> tx_data_o inside {8'h01, 8'h02, 8'h03, 8'h06};
  endproperty
  property p_six;
    tx_valid_o && tx_last_o && (fc_q == 8'h10 || fc_q == 8'h46) |-> len_q == 16'h0006;
  endproperty
  a_rst: assert property (p_rst) else $error("outputs not idle after reset");
  a_hold: assert property (p_hold) else $error("stalled byte changed");
  a_blk: assert property (p_blk) else $error("query taken during response");
  a_wr: assert property (p_wr) else $error("write strobe longer than one cycle");
  a_pro: assert property (p_pro) else $error("protocol field not zero");
  a_len: assert property (p_len) else $error("length field wrong");
  a_err_end: assert property (p_err_end) else $error("error response too long");
  a_exc: assert property (p_exc) else $error("bad exception code");
  a_six: assert property (p_six) else $error("echo length not six");
endmodule // mtsf_checker

/* File: bench/tb.sv */
// Self-checking testbench of the framing block
`timescale 1ns/10ps
module tb;
  logic clock_i = 1'b0;
  logic reset_i = 1'b1;
  logic [7:0] rx_data_i = 8'h00;
  logic rx_valid_i = 1'b0;
  logic tx_ready_i = 1'b0;
  logic busy = 1'b0;
  wire rx_ready_o, tx_last_o, tx_valid_o, acc_req_o, acc_we_o, ok, bsy;
  wire [7:0] tx_data_o;
  wire [15:0] acc_addr_o, acc_wdata_o, rdata;
  logic [7:0] sq[$];
  logic [7:0] eq[$];
  int num_errors = 0;
  int compares = 0;
  always #20 clock_i = ~clock_i;
  mtsf_core mtsf_core_i (.clock_i(clock_i), .reset_i(reset_i), .ce_i(1'b1), .rx_data_i(rx_data_i),
    .rx_valid_i(rx_valid_i), .rx_ready_o(rx_ready_o), .tx_data_o(tx_data_o), .tx_last_o(tx_last_o),
    .tx_valid_o(tx_valid_o), .tx_ready_i(tx_ready_i), .acc_req_o(acc_req_o), .acc_we_o(acc_we_o),
    .acc_addr_o(acc_addr_o), .acc_wdata_o(acc_wdata_o), .acc_rdata_i(rdata), .acc_ok_i(ok), .acc_busy_i(bsy));
  mtsf_store mtsf_store_i (.clock_i(clock_i), .req_i(acc_req_o), .we_i(acc_we_o), .addr_i(acc_addr_o),
    .wdata_i(acc_wdata_o), .busy_i(busy), .rdata_o(rdata), .ok_o(ok), .busy_o(bsy));
  // ----------------------------------------
  // Frame helpers
  // ----------------------------------------
  task cmp8(input logic [7:0] g, input logic [7:0] e);
    compares++;
    if (g !== e) begin
      num_errors++;
      $display("mismatch %0t byte %h expected %h", $time, g, e);
    end
  endtask
  task cmp1(input logic g, input logic e);
    compares++;
    if (g !== e) begin
      num_errors++;
      $display("mismatch %0t flag %b expected %b", $time, g, e);
    end
  endtask
  task put(input bit tx, input logic [7:0] b);
    if (tx) eq.push_back(b);
    else sq.push_back(b);
  endtask
  task w16(input bit tx, input logic [15:0] v);
    put(tx, v[15:8]);
    put(tx, v[7:0]);
  endtask
  task hd(input bit tx, input logic [15:0] t, input logic [15:0] p, input logic [15:0] l,
          input logic [7:0] u, input logic [7:0] f);
    w16(tx, t);
    w16(tx, p);
    w16(tx, l);
    put(tx, u);
    put(tx, f);
  endtask
  task send;
    int i;
    for (i = 0; i < sq.size(); i++) begin
      @(negedge clock_i);
      while (rx_ready_o !== 1'b1) @(negedge clock_i);
      rx_data_i = sq[i];
      rx_valid_i = 1'b1;
    end
    @(negedge clock_i);
    rx_valid_i = 1'b0;
    sq.delete();
  endtask
  task get_r(input int stall);
    int k;
    int n;
    k = 0;
    n = 0;
    while (n < eq.size() && k < 3000) begin
      @(negedge clock_i);
      tx_ready_i = (k >= stall) && (k % 3 != 1);
      if (tx_valid_o === 1'b1 && tx_ready_i) begin
        cmp8(tx_data_o, eq[n]);
        cmp1(tx_last_o, n == eq.size() - 1);
        n++;
      end
      k++;
    end
    @(negedge clock_i);
    tx_ready_i = 1'b0;
    cmp1(n == eq.size(), 1'b1);
    repeat (3) @(negedge clock_i);
    cmp1(tx_valid_o, 1'b0);
    eq.delete();
  endtask
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task t_read;
    hd(0, 16'h1234, 16'h0000, 16'h0006, 8'hff, 8'h03);
    w16(0, 16'h6048);
    w16(0, 16'h0004);
    send;
    hd(1, 16'h1234, 16'h0000, 16'h000b, 8'hff, 8'h03);
    put(1, 8'h08);
    w16(1, 16'h0002);
    w16(1, 16'h0708);
    w16(1, 16'h0000);
    w16(1, 16'h0005);
    get_r(20);
  endtask
  task t_log(input logic [7:0] u, input logic [15:0] st, input logic [15:0] n);
    hd(0, 16'hbeef, 16'h0000, 16'h0002, u, 8'h46);
    send;
    hd(1, 16'hbeef, 16'h0000, 16'h0006, u, 8'h46);
    w16(1, st);
    w16(1, n);
    get_r(0);
  endtask
  task t_write;
    hd(0, 16'h0042, 16'h0000, 16'h000b, 8'hff, 8'h10);
    w16(0, 16'h6049);
    w16(0, 16'h0002);
    put(0, 8'h04);
    w16(0, 16'h1111);
    w16(0, 16'h2222);
    send;
    hd(1, 16'h0042, 16'h0000, 16'h0006, 8'hff, 8'h10);
    w16(1, 16'h6049);
    w16(1, 16'h0002);
    get_r(0);
    hd(0, 16'h0043, 16'h0000, 16'h0006, 8'h00, 8'h03);
    w16(0, 16'h6049);
    w16(0, 16'h0002);
    send;
    hd(1, 16'h0043, 16'h0000, 16'h0007, 8'h00, 8'h03);
    put(1, 8'h04);
    w16(1, 16'h1111);
    w16(1, 16'h2222);
    get_r(0);
  endtask
  logic [7:0] fe [0:3] = '{8'h05, 8'h03, 8'h03, 8'h03};
  logic [15:0] se [0:3] = '{16'h6048, 16'h6048, 16'h0100, 16'h6048};
  logic [15:0] qe [0:3] = '{16'h0001, 16'h0000, 16'h0001, 16'h0001};
  logic [7:0] ce [0:3] = '{8'h01, 8'h03, 8'h02, 8'h06};
  task t_err;
    int i;
    for (i = 0; i < 4; i++) begin
      busy = (i == 3);
      hd(0, i[15:0], 16'h0000, 16'h0006, 8'h00, fe[i]);
      w16(0, se[i]);
      w16(0, qe[i]);
      send;
      hd(1, i[15:0], 16'h0000, 16'h0003, 8'h00, fe[i] | 8'h80);
      put(1, ce[i]);
      get_r(0);
      busy = 1'b0;
    end
    // Write to an absent register answers address error
    hd(0, 16'h0099, 16'h0000, 16'h0009, 8'h00, 8'h10);
    w16(0, 16'h0100);
    w16(0, 16'h0001);
    put(0, 8'h02);
    w16(0, 16'habcd);
    send;
    hd(1, 16'h0099, 16'h0000, 16'h0003, 8'h00, 8'h90);
    put(1, 8'h02);
    get_r(0);
  endtask
  task t_drop;
    hd(0, 16'h0666, 16'h0001, 16'h0006, 8'hff, 8'h03);
    w16(0, 16'h604b);
    w16(0, 16'h0001);
    hd(0, 16'h0667, 16'h0000, 16'h0006, 8'h07, 8'h03);
    w16(0, 16'h604b);
    w16(0, 16'h0001);
    hd(0, 16'h0777, 16'h0000, 16'h0006, 8'hff, 8'h03);
    w16(0, 16'h604b);
    w16(0, 16'h0001);
    send;
    hd(1, 16'h0777, 16'h0000, 16'h0005, 8'hff, 8'h03);
    put(1, 8'h02);
    w16(1, 16'h0005);
    get_r(0);
  endtask
  task final_report;
    if (num_errors == 0 && compares > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  initial begin
    #800000;
    num_errors++;
    $display("mismatch %0t watchdog expired", $time);
    final_report;
  end
  initial begin
    repeat (10) @(negedge clock_i);
    reset_i = 1'b0;
    t_read;
    t_log(8'h00, 16'h6048, 16'h0004);
    t_log(8'hff, 16'h0000, 16'h0000);
    t_write;
    t_err;
    t_drop;
    final_report;
  end
endmodule // tb
bind mtsf_core mtsf_checker mtsf_checker_i (.clock_i(clock_i), .reset_i(reset_i), .rx_ready_o(rx_ready_o),
  .tx_data_o(tx_data_o), .tx_last_o(tx_last_o), .tx_valid_o(tx_valid_o), .tx_ready_i(tx_ready_i),
  .acc_req_o(acc_req_o), .acc_we_o(acc_we_o));
